// [hw/pexd_core.sv]
// Purpose: Page erase command sequencer and XiP dummy clock selector.
// Assumes: SPI mode 0 or 3, SI sampled on rising SCK; SCK stands still outside frames.
// Notes: Frame words cross to clk while SCK is idle, qualified by a synchronised toggle.
`timescale 1ns/1ps
`default_nettype none

module pexd_core #(
    parameter int PE_CYCLES = pexd_pkg::PAGE_ERASE_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    input wire logic [7:0] status_reg5,
    input wire logic [7:0] xip_opcode,
    input wire logic wren_set,
    input wire logic wren_clear,
    input wire logic erase_protect,
    output logic write_latch_flag,
    output logic erase_busy,
    output logic erase_start,
    output logic erase_done,
    output logic erase_abort,
    output logic [10:0] page_index,
    output logic [3:0] dummy_clocks,
    output logic xip_dword_aligned,
    output logic xip_cfg_valid
);

    typedef enum logic [1:0] {
        PEXD_IDLE = 2'b00,
        PEXD_ERASE = 2'b01
    } pexd_state_t;

    // ------------------------------------------------------------
    // Link domain: frame shifter on SCK
    // ------------------------------------------------------------
    logic [pexd_pkg::FRAME_CNT_W-1:0] bit_cnt_r;
    logic [pexd_pkg::FRAME_CNT_W-1:0] bit_cnt_nxt;
    logic [pexd_pkg::FRAME_CNT_W-1:0] frame_bits_r;
    logic [pexd_pkg::FRAME_BITS-1:0] shift_r;
    logic start_tgl_r;
    logic [7:0] opcode_r;

    // Past 32 bits the count keeps bit 5 set and its low bits byte-modular
    always_comb begin
        bit_cnt_nxt = bit_cnt_r + 6'h01;
        if (bit_cnt_r[5]) begin
            bit_cnt_nxt = {1'b1, bit_cnt_r[4:0] + 5'h01};
        end
    end

    // Chip select high clears the count without needing an SCK edge
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt_r <= '0;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    // Not cleared by chip select, so the count survives the frame end
    always_ff @(posedge spi_sck) begin
        frame_bits_r <= bit_cnt_nxt;
    end

    // Opcode then address, MSB first on SI; later bits are not kept
    always_ff @(posedge spi_sck) begin
        if (!bit_cnt_r[5]) begin
            shift_r <= {shift_r[pexd_pkg::FRAME_BITS-2:0], spi_si};
        end
    end

    // Opcode kept apart so a short frame still shows what it asked for
    always_ff @(posedge spi_sck) begin
        if (bit_cnt_r == 6'h00) begin
            opcode_r <= 8'h00;
        end else if (bit_cnt_r == 6'h07) begin
            opcode_r <= {shift_r[6:0], spi_si};
        end
    end

    // Marks a frame that saw at least one clock
    always_ff @(posedge spi_sck or posedge srst) begin
        if (srst) begin
            start_tgl_r <= 1'b0;
        end else if (bit_cnt_r == '0) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    // ------------------------------------------------------------
    // Crossing into clk
    // ------------------------------------------------------------
    logic cs_n_s;
    logic tgl_s;
    logic cs_n_q_r;
    logic tgl_seen_r;
    logic cs_rise;

    pexd_sync #(
        .WIDTH(2),
        .RST_VAL(2'b10)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .d({spi_cs_n, start_tgl_r}),
        .q({cs_n_s, tgl_s})
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            cs_n_q_r <= 1'b1;
        end else begin
            cs_n_q_r <= cs_n_s;
        end
    end

    assign cs_rise = cs_n_s & ~cs_n_q_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            tgl_seen_r <= 1'b0;
        end else if (cs_rise) begin
            tgl_seen_r <= tgl_s;
        end
    end

    // ------------------------------------------------------------
    // Frame decode at chip select rise
    // ------------------------------------------------------------
    // Frame words are read only at cs_rise: SCK has been idle for at
    // least the two synchroniser cycles, so they are stable by then.
    logic edges_seen;
    logic bits_aligned;
    logic addr_full;
    logic is_page_erase;
    logic erase_go;
    logic [7:0] frame_opcode;

    assign frame_opcode = opcode_r;
    assign edges_seen = tgl_s != tgl_seen_r;
    assign bits_aligned = frame_bits_r[2:0] == 3'h0;
    assign addr_full = frame_bits_r[5];
    assign is_page_erase = (frame_opcode == pexd_pkg::OP_PAGE_ERASE_A) ||
                           (frame_opcode == pexd_pkg::OP_PAGE_ERASE_B);

    // Busy device ignores a new erase; protection blocks it outright
    assign erase_go = cs_rise & edges_seen & is_page_erase & bits_aligned & addr_full &
                      write_latch_flag & ~erase_protect & ~erase_busy;

    // ------------------------------------------------------------
    // Erase sequencer
    // ------------------------------------------------------------
    pexd_state_t state_r;
    logic [31:0] timer_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= PEXD_IDLE;
            timer_r <= '0;
            erase_busy <= 1'b0;
            erase_done <= 1'b0;
        end else begin
            erase_done <= 1'b0;
            case (state_r)
                PEXD_IDLE: begin
                    if (erase_go) begin
                        state_r <= PEXD_ERASE;
                        timer_r <= 32'(PE_CYCLES - 1);
                        erase_busy <= 1'b1;
                    end
                end
                PEXD_ERASE: begin
                    if (timer_r == '0) begin
                        state_r <= PEXD_IDLE;
                        erase_busy <= 1'b0;
                        erase_done <= 1'b1;
                    end else begin
                        timer_r <= timer_r - 32'h0000_0001;
                    end
                end
                default: begin
                    state_r <= PEXD_IDLE;
                    erase_busy <= 1'b0;
                end
            endcase
        end
    end

    // Array request: one pulse with the page held until the next erase
    always_ff @(posedge clk) begin
        if (srst) begin
            erase_start <= 1'b0;
            page_index <= '0;
        end else begin
            erase_start <= erase_go;
            if (erase_go) begin
                page_index <= shift_r[pexd_pkg::PAGE_ADDR_MSB:pexd_pkg::PAGE_ADDR_LSB];
            end
        end
    end

    // Rejected page erase frames, for status reporting
    always_ff @(posedge clk) begin
        if (srst) begin
            erase_abort <= 1'b0;
        end else begin
            erase_abort <= cs_rise & edges_seen & is_page_erase & ~erase_go;
        end
    end

    // ------------------------------------------------------------
    // Write latch flag
    // ------------------------------------------------------------
    // Set wins so a write enable landing on the clear is kept
    always_ff @(posedge clk) begin
        if (srst) begin
            write_latch_flag <= 1'b0;
        end else if (wren_set) begin
            write_latch_flag <= 1'b1;
        end else if (wren_clear || erase_go) begin
            write_latch_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // XiP dummy clock selection
    // ------------------------------------------------------------
    logic [2:0] dummy_code;
    logic align_sel;
    logic xip_op;
    logic code_ok;

    assign dummy_code = status_reg5[pexd_pkg::SR5_DUMMY_CODE_MSB:pexd_pkg::SR5_DUMMY_CODE_LSB];
    assign align_sel = status_reg5[pexd_pkg::SR5_ALIGN_SEL_BIT];
    assign xip_op = (xip_opcode == pexd_pkg::OP_XIP_READ) ||
                    (xip_opcode == pexd_pkg::OP_XIP_READ_DW);
    assign code_ok = dummy_code <= pexd_pkg::DUMMY_CODE_MAX;

    // Mode-bit clocks live inside this count; the read path adds none
    always_ff @(posedge clk) begin
        if (srst) begin
            dummy_clocks <= pexd_pkg::DUMMY_RESET;
            xip_cfg_valid <= 1'b0;
        end else begin
            xip_cfg_valid <= xip_op & code_ok;
            if (code_ok) begin
                dummy_clocks <= pexd_pkg::DUMMY_BASE + {dummy_code, 1'b0};
            end else begin
                // Undefined codes fall back to the longest, safest count
                dummy_clocks <= pexd_pkg::DUMMY_BASE + {pexd_pkg::DUMMY_CODE_MAX, 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            xip_dword_aligned <= 1'b0;
        end else if (xip_opcode == pexd_pkg::OP_XIP_READ_DW) begin
            xip_dword_aligned <= 1'b1;
        end else if (xip_opcode == pexd_pkg::OP_XIP_READ) begin
            xip_dword_aligned <= align_sel;
        end else begin
            xip_dword_aligned <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [31:0] busy_len_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            busy_len_r <= '0;
        end else if (erase_start) begin
            busy_len_r <= 32'h0000_0001;
        end else if (erase_busy) begin
            busy_len_r <= busy_len_r + 32'h0000_0001;
        end
    end

    sequence s_erase_begin;
        erase_start && erase_busy;
    endsequence

    sequence s_erase_hold;
        erase_busy [*8];
    endsequence

    a_dummy_map: assert property (@(posedge clk) disable iff (srst)
        (xip_op && code_ok) |=>
        (int'(dummy_clocks) == 2 + 2 * int'($past(dummy_code))) && xip_cfg_valid)
        else $error("dummy clock count does not follow the code");

    a_dummy_undef: assert property (@(posedge clk) disable iff (srst)
        (dummy_code > 3'h4) |=> !xip_cfg_valid && (dummy_clocks == 4'ha))
        else $error("undefined dummy code accepted");

    a_e7_align: assert property (@(posedge clk) disable iff (srst)
        (xip_opcode == pexd_pkg::OP_XIP_READ_DW) |=> xip_dword_aligned)
        else $error("E7 read not double-word aligned");

    a_eb_align: assert property (@(posedge clk) disable iff (srst)
        (xip_opcode == pexd_pkg::OP_XIP_READ) |=> (xip_dword_aligned == $past(align_sel)))
        else $error("EB alignment ignores select bit");

    a_erase_opcode: assert property (@(posedge clk) disable iff (srst)
        (cs_rise && !is_page_erase) |=> !erase_start)
        else $error("erase started by wrong opcode");

    a_erase_begin: assert property (@(posedge clk) disable iff (srst)
        $rose(erase_busy) |-> s_erase_begin ##1 s_erase_hold)
        else $error("busy not held after erase start");

    a_erase_length: assert property (@(posedge clk) disable iff (srst)
        $fell(erase_busy) |-> (busy_len_r == 32'(PE_CYCLES)) && erase_done)
        else $error("erase time wrong");

    a_page_pick: assert property (@(posedge clk) disable iff (srst)
        erase_start |-> (page_index == $past(shift_r[18:8])))
        else $error("page index taken from wrong bits");

    a_latch_clear: assert property (@(posedge clk) disable iff (srst)
        erase_start |-> (!write_latch_flag || $past(wren_set)))
        else $error("write latch flag kept through erase");

    a_byte_abort: assert property (@(posedge clk) disable iff (srst)
        (cs_rise && (frame_bits_r[2:0] != 3'h0)) |=> !erase_start)
        else $error("erase started off byte boundary");

    a_short_abort: assert property (@(posedge clk) disable iff (srst)
        (cs_rise && edges_seen && is_page_erase && !frame_bits_r[5]) |=>
        (erase_abort && !erase_start))
        else $error("erase started with short address");

    a_protect_block: assert property (@(posedge clk) disable iff (srst)
        (cs_rise && erase_protect && !erase_busy) |=> !erase_start && !erase_busy)
        else $error("protected memory erased");

    a_need_latch: assert property (@(posedge clk) disable iff (srst)
        (cs_rise && !write_latch_flag) |=> !erase_start)
        else $error("erase without write latch flag");

endmodule

`default_nettype wire

// [hw/pexd_pkg.sv]
// Purpose: Shared constants for the page erase sequencer and XiP dummy clock selector.
// Assumes: System clock of 125 MHz; the SPI host drives SCK and chip select.
// Notes: The erase time default is a plain value; the top module can override the count.
//
// Overview of operation
// - Dummy clock count for quad XiP reads comes from status register 5 bits 6:4.
// - Codes 000..100 give 2, 4, 6, 8, 10 dummy clocks for both XiP opcodes.
// - Dummy count already holds the two mode-bit clocks; none are added.
// - EBh read uses word aligned or unaligned mode from status register 5 bit 0.
// - E7h read is always double-word aligned and ignores the alignment select bit.
// - Opcode 81h or DBh requests erase of one page of the main array.
// - Page erase moves opcode and address on the serial input only, no data.
// - Opcode takes eight clocks, most significant bit first.
// - Three address bytes follow over 24 clocks, address bit 23 first.
// - Page index is address bits 18:8; bits 23:19 and 7:0 are ignored.
// - Erase of the selected page starts when chip select rises; page becomes ones.
// - Erase is self-timed within page erase time and reports busy throughout.
// - Write latch flag is cleared before the erase cycle completes; the code clears it at erase start unless wren_set is high then.
// - Chip select rising off a byte boundary aborts the erase with no action.
// - Fewer than three full address bytes at chip select rise aborts the erase.
// - Protected memory is not erased; device returns idle after chip select rises.

package pexd_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 125;
    localparam int PAGE_ERASE_TIME_US = 20000;
    // Longest time, rounded down to whole cycles
    localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_TIME_US * CLK_FREQ_MHZ;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_PAGE_ERASE_A = 8'h81;
    localparam logic [7:0] OP_PAGE_ERASE_B = 8'hdb;
    localparam logic [7:0] OP_XIP_READ = 8'heb;
    localparam logic [7:0] OP_XIP_READ_DW = 8'he7;

    // ------------------------------------------------------------
    // Status register 5 fields
    // ------------------------------------------------------------
    localparam int SR5_DUMMY_CODE_MSB = 6;
    localparam int SR5_DUMMY_CODE_LSB = 4;
    localparam int SR5_ALIGN_SEL_BIT = 0;

    // ------------------------------------------------------------
    // Dummy clock mapping
    // ------------------------------------------------------------
    localparam logic [3:0] DUMMY_BASE = 4'h2;
    localparam logic [2:0] DUMMY_CODE_MAX = 3'h4;
    localparam logic [3:0] DUMMY_RESET = 4'h2;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_CNT_W = 6;
    localparam int FRAME_BITS = 32;
    localparam int OPCODE_MSB = 31;
    localparam int OPCODE_LSB = 24;
    localparam int PAGE_ADDR_MSB = 18;
    localparam int PAGE_ADDR_LSB = 8;
    localparam int PAGE_INDEX_W = 11;

endpackage

// [hw/pexd_sync.sv]
// Purpose: Two flip-flop synchroniser for levels entering the system clock domain.
// Assumes: Each bit is an independent level or a toggle.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/1ps
`default_nettype none

module pexd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

`default_nettype wire

// [verif/pexd_host_model.sv]
// Purpose: SPI host stand-in that shifts page erase frames into the sequencer.
// Assumes: Mode 0; SCK period 125 ns, started at an odd offset to the system clock.
// Notes: SCK stands still between frames; SI shows the inverse of its last bit when idle.
`timescale 1ns/1ps
`default_nettype none

module pexd_host_model (
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_si
);

    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b1;
    end

    // ------------------------------------------------------------
    // Frame shifter
    // ------------------------------------------------------------
    // Single line only, no data phase follows the address
    task automatic send_frame(input logic [39:0] bits, input int nbits);
        int i;
        #3.3;
        spi_cs_n = 1'b0;
        #31.25;
        // 8 MHz SCK stays below the limit of every dummy setting
        for (i = 0; i < nbits; i++) begin
            spi_si = bits[39 - i];
            #31.25;
            spi_sck = 1'b1;
            #62.5;
            spi_sck = 1'b0;
            #31.25;
        end
        // Keep the last edge well ahead of chip select rising
        #31.25;
        spi_cs_n = 1'b1;
        spi_si = ~spi_si;
    endtask

endmodule
`default_nettype wire

// [verif/tb_page_erase_and_xip_dummy_cfg.sv]
// Purpose: Self-checking bench for the page erase sequencer and dummy clock selector.
// Assumes: Erase time shortened to PE cycles so a frame fits inside one erase.
// Notes: Only mismatches and the verdict are printed.
`timescale 1ns/1ps
`default_nettype none

`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin failures++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp); end end

module tb_page_erase_and_xip_dummy_cfg;

    localparam int PE = 1000;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic spi_sck, spi_cs_n, spi_si;
    logic [7:0] status_reg5 = 8'h00;
    logic [7:0] xip_opcode = 8'h00;
    logic wren_set = 1'b0;
    logic wren_clear = 1'b0;
    logic erase_protect = 1'b0;
    logic write_latch_flag, erase_busy, erase_start, erase_done, erase_abort;
    logic xip_dword_aligned, xip_cfg_valid;
    logic [10:0] page_index;
    logic [3:0] dummy_clocks;
    logic [10:0] exp_page = 11'h000;
    int failures = 0;
    int compares = 0;
    int starts = 0;
    int aborts = 0;
    int busy_cnt = 0;

    pexd_host_model host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si));

    pexd_core #(.PE_CYCLES(PE)) dut (
        .clk(clk), .srst(srst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
        .status_reg5(status_reg5), .xip_opcode(xip_opcode), .wren_set(wren_set),
        .wren_clear(wren_clear), .erase_protect(erase_protect),
        .write_latch_flag(write_latch_flag), .erase_busy(erase_busy),
        .erase_start(erase_start), .erase_done(erase_done), .erase_abort(erase_abort),
        .page_index(page_index), .dummy_clocks(dummy_clocks),
        .xip_dword_aligned(xip_dword_aligned), .xip_cfg_valid(xip_cfg_valid)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Pulse monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (erase_start === 1'b1) begin
            starts++;
            `CHK(page_index, exp_page)
            `CHK(write_latch_flag, 1'b0)
            `CHK(erase_busy, 1'b1)
        end
        if (erase_abort === 1'b1) aborts++;
        if (erase_busy === 1'b1) busy_cnt++;
        if (erase_done === 1'b1) begin
            `CHK(busy_cnt, PE)
            busy_cnt = 0;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (failures == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic pulse_wren(input logic set);
        @(posedge clk);
        wren_set <= set;
        wren_clear <= ~set;
        @(posedge clk);
        wren_set <= 1'b0;
        wren_clear <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(write_latch_flag, set)
    endtask

    task automatic check_cfg(input logic [7:0] op, input logic [2:0] code, input logic word_aligned_select);
        logic xip;
        logic [3:0] exp_d;
        xip = (op == pexd_pkg::OP_XIP_READ) || (op == pexd_pkg::OP_XIP_READ_DW);
        exp_d = (code <= 3'h4) ? 4'h2 + {code, 1'b0} : 4'ha;
        @(posedge clk);
        status_reg5 <= {1'b1, code, 3'h7, word_aligned_select};
        xip_opcode <= op;
        @(posedge clk);
        #1;
        `CHK(xip_cfg_valid, xip && (code <= 3'h4))
        if (xip) `CHK(dummy_clocks, exp_d)
        if (op == pexd_pkg::OP_XIP_READ) `CHK(xip_dword_aligned, word_aligned_select)
        if (op == pexd_pkg::OP_XIP_READ_DW) `CHK(xip_dword_aligned, 1'b1)
    endtask

    // Answer lands on the third clock edge after chip select rises; 12 leaves margin
    task automatic erase_frame(input logic [39:0] bits, input int nbits, input int exp_s,
                               input int exp_a);
        @(posedge clk);
        #1;
        starts = 0;
        aborts = 0;
        host.send_frame(bits, nbits);
        repeat (12) @(posedge clk);
        #1;
        `CHK(starts, exp_s)
        `CHK(aborts, exp_a)
    endtask

    task automatic wait_idle();
        int n;
        for (n = 0; n < PE + 50 && erase_busy !== 1'b0; n++) @(posedge clk);
        if (erase_busy !== 1'b0) begin
            failures++;
            print_verdict();
        end
        repeat (3) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] ops [3];
        logic [7:0] pe_ops [2];
        ops = '{8'heb, 8'he7, 8'h03};
        pe_ops = '{pexd_pkg::OP_PAGE_ERASE_A, pexd_pkg::OP_PAGE_ERASE_B};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(write_latch_flag, 1'b0)
        `CHK(erase_busy, 1'b0)
        `CHK(dummy_clocks, 4'h2)
        for (int o = 0; o < 3; o++) begin
            for (int c = 0; c < 8; c++) begin
                check_cfg(ops[o], c[2:0], 1'b0);
                check_cfg(ops[o], c[2:0], 1'b1);
            end
        end
        pulse_wren(1'b1);
        pulse_wren(1'b0);
        // Both opcodes, don't-care address bits at opposite levels
        for (int k = 0; k < 2; k++) begin
            pulse_wren(1'b1);
            exp_page = (k == 0) ? 11'h5a3 : 11'h2c6;
            erase_frame({pe_ops[k], {5{k == 0}}, exp_page, {8{k == 0}}, 8'h00}, 32, 1, 0);
            wait_idle();
        end
        // Refused without write enable, flag stays low
        erase_frame({8'h81, 24'h000100, 8'h00}, 32, 0, 1);
        pulse_wren(1'b1);
        erase_frame({8'hdb, 24'h000100, 8'h00}, 31, 0, 1);
        erase_frame({8'h81, 24'h000100, 8'h00}, 24, 0, 1);
        @(posedge clk);
        erase_protect <= 1'b1;
        erase_frame({8'h81, 24'h000100, 8'h00}, 32, 0, 1);
        @(posedge clk);
        erase_protect <= 1'b0;
        erase_frame({8'h82, 24'h000100, 8'h00}, 32, 0, 0);
        `CHK(write_latch_flag, 1'b1)
        // Second frame lands while the first erase still runs
        exp_page = 11'h7ff;
        erase_frame({8'h81, 24'h07ff00, 8'h00}, 32, 1, 0);
        pulse_wren(1'b1);
        erase_frame({8'h81, 24'h000200, 8'h00}, 32, 0, 1);
        `CHK(erase_busy, 1'b1)
        wait_idle();
        print_verdict();
    end

endmodule
`undef CHK
`default_nettype wire
